// ===== rtl/smsc_misc_regs.sv
// Miscellaneous system identity, byte-order probe and hardware setup registers.
//
// Function
// - Identity word read-only: chip code, revision.
// - Endian probe returns fixed pattern, read-only.
// - Endian probe readable during soft or digital reset, not ready.
// - Either 16-bit half readable alone.
// - Setup register pollable before ready.
// - Ready bit 27 sets after reset settles.
// - Ready rising raises interrupt when enabled.
// - Writes ignored until ready is set.
// - Ready flag mirrors power register bit 0; the code only drives pmt_ready, that offset reads zero.
// - Bits 26/25 mirror port crossover straps.
// - Straps captured at reset, loader may overwrite.
// - PHY control bits 15/13 override strap.
// - Bit 0 write triggers self-clearing soft reset.
`timescale 1ns/1ps
`include "smsc_defs.svh"
module smsc_misc_regs
  import smsc_pkg::*;
#(
  parameter logic [15:0] CHIP_CODE = 16'hA5C3, // Arbitrary identity value.
  parameter logic [15:0] CHIP_REV = 16'h0001, // Arbitrary revision value.
  parameter int SETTLE_CYC = (`SMSC_READY_TIME_NS + `SMSC_CLK_PERIOD_NS - 1) / `SMSC_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Host register access, 16-bit halves.
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // Other reset sources.
  input wire logic digital_reset,
  // Strap levels and configuration loader.
  input wire logic strap_xovr1,
  input wire logic strap_xovr2,
  input wire logic loader_wr,
  input wire logic loader_xovr1,
  input wire logic loader_xovr2,
  // PHY special control words per port.
  input wire logic [15:0] phy1_special_ctrl,
  input wire logic [15:0] phy2_special_ctrl,
  // Ready interrupt enable from the interrupt block.
  input wire logic ready_irq_en,
  // Outputs.
  output logic ready_irq,
  output logic pmt_ready,
  output logic soft_reset_out,
  output logic phy1_xovr_en,
  output logic phy2_xovr_en,
  output logic cfg_mbo,
  output logic cfg_rsvd
);
  logic ready;
  logic strap_cap_reg, strap_cap_next;
  logic strap1_lat_reg, strap1_lat_next;
  logic strap2_lat_reg, strap2_lat_next;
  logic xovr1_reg, xovr1_next;
  logic xovr2_reg, xovr2_next;
  logic rsvd_reg, rsvd_next;
  logic mbo_reg, mbo_next;
  logic [2:0] software_reset_bit_cnt_reg, software_reset_bit_cnt_next;
  logic software_reset_bit_reg, software_reset_bit_next;
  logic ready_d_reg, ready_d_next;
  logic irq_reg, irq_next;
  logic [15:0] rdata_reg, rdata_next;
  logic p1_reg, p1_next;
  logic p2_reg, p2_next;
  smsc_word_t hw_word;
  smsc_word_t rd_word;
  logic wr_ok;

  // Effective crossover: PHY override wins over strap value.
  function automatic logic xovr_eff(input logic [15:0] ctl, input logic strap);
    xovr_eff = ctl[`SMSC_PHY_OVR_EN_BIT] ? ctl[`SMSC_PHY_OVR_VAL_BIT] : strap;
  endfunction

  // Word offset of a host address; the half-select bit is dropped.
  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    word_ofs = a & `SMSC_WORD_MASK;
  endfunction

  // Ready settling sequence restarted by soft or digital reset.
  smsc_ready_seq #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_ready (
    .core_clk(core_clk),
    .reset(reset),
    .restart(software_reset_bit_reg | digital_reset),
    .ready(ready)
  );

  // Assemble the setup word; unlisted bits stay zero.
  always_comb begin
    hw_word = 32'h0000_0000;
    hw_word[`SMSC_BIT_READY] = ready;
    hw_word[`SMSC_BIT_XOVR2] = xovr2_reg;
    hw_word[`SMSC_BIT_XOVR1] = xovr1_reg;
    hw_word[`SMSC_BIT_RSVD_RW] = rsvd_reg;
    hw_word[`SMSC_BIT_MBO] = mbo_reg;
    hw_word[`SMSC_BIT_SOFTWARE_RESET_BIT] = software_reset_bit_reg | digital_reset;
  end

  // Read mux; probe and setup answer regardless of ready.
  always_comb begin
    rd_word = 32'h0000_0000; // unmapped reads zero
    case (word_ofs(host_addr))
      `SMSC_OFS_CHIP_ID: rd_word = {CHIP_CODE, CHIP_REV};
      `SMSC_OFS_ENDIAN: rd_word = `SMSC_ENDIAN_PATTERN;
      `SMSC_OFS_HW_SETUP: rd_word = hw_word;
      default: rd_word = 32'h0000_0000;
    endcase
    // half select by address bit 1
    rdata_next = host_addr[1] ? rd_word[31:16] : rd_word[15:0];
    if (!host_rd) begin
      rdata_next = rdata_reg;
    end
  end

  // Write and event logic.
  always_comb begin
    wr_ok = host_wr & ready & (word_ofs(host_addr) == `SMSC_OFS_HW_SETUP);
    // straps follow pins while reset held
    strap1_lat_next = reset ? strap_xovr1 : strap1_lat_reg;
    strap2_lat_next = reset ? strap_xovr2 : strap2_lat_reg;
    strap_cap_next = 1'b1;
    xovr1_next = xovr1_reg;
    xovr2_next = xovr2_reg;
    if (!strap_cap_reg) begin
      xovr1_next = strap1_lat_reg;
      xovr2_next = strap2_lat_reg;
    end else if (loader_wr) begin
      xovr1_next = loader_xovr1;
      xovr2_next = loader_xovr2;
    end
    rsvd_next = rsvd_reg;
    mbo_next = mbo_reg;
    software_reset_bit_next = 1'b0;
    software_reset_bit_cnt_next = software_reset_bit_cnt_reg;
    if (software_reset_bit_cnt_reg != 3'h0) begin
      software_reset_bit_cnt_next = software_reset_bit_cnt_reg - 3'h1;
      software_reset_bit_next = 1'b1;
    end
    if (wr_ok && host_addr[1]) begin
      rsvd_next = host_wdata[`SMSC_BIT_RSVD_RW - 16];
      mbo_next = host_wdata[`SMSC_BIT_MBO - 16];
    end
    if (wr_ok && !host_addr[1] && host_wdata[`SMSC_BIT_SOFTWARE_RESET_BIT]) begin
      software_reset_bit_cnt_next = 3'(`SMSC_SOFTWARE_RESET_BIT_PULSE_CYC);
      software_reset_bit_next = 1'b1;
    end
    // Soft reset returns the host-writable upper-half bits, rsvd and mbo, to defaults.
    if (software_reset_bit_reg) begin
      rsvd_next = 1'b0;
      mbo_next = 1'b0;
    end
    ready_d_next = ready;
    irq_next = ready & ~ready_d_reg & ready_irq_en;
    p1_next = xovr_eff(phy1_special_ctrl, xovr1_reg);
    p2_next = xovr_eff(phy2_special_ctrl, xovr2_reg);
  end

  // Register stage.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strap_cap_reg <= 1'b0;
      xovr1_reg <= 1'b0;
      xovr2_reg <= 1'b0;
      rsvd_reg <= 1'b0;
      mbo_reg <= 1'b0;
      software_reset_bit_cnt_reg <= 3'h0;
      software_reset_bit_reg <= 1'b0;
      ready_d_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      p1_reg <= 1'b0;
      p2_reg <= 1'b0;
    end else begin
      strap_cap_reg <= strap_cap_next;
      xovr1_reg <= xovr1_next;
      xovr2_reg <= xovr2_next;
      rsvd_reg <= rsvd_next;
      mbo_reg <= mbo_next;
      software_reset_bit_cnt_reg <= software_reset_bit_cnt_next;
      software_reset_bit_reg <= software_reset_bit_next;
      ready_d_reg <= ready_d_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
    end
  end

  // Strap latch has no reset, so it can follow the pin levels while reset is held.
  always_ff @(posedge core_clk) begin
    strap1_lat_reg <= strap1_lat_next;
    strap2_lat_reg <= strap2_lat_next;
  end

  // Outputs straight from flip-flops.
  assign host_rdata = rdata_reg;
  assign ready_irq = irq_reg;
  assign pmt_ready = ready;
  assign soft_reset_out = software_reset_bit_reg;
  assign phy1_xovr_en = p1_reg;
  assign phy2_xovr_en = p2_reg;
  assign cfg_mbo = mbo_reg;
  assign cfg_rsvd = rsvd_reg;
endmodule

// ===== rtl/smsc_defs.svh
// Offsets, field positions, the probe pattern and timing counts for the misc register bank.
`ifndef SMSC_DEFS_SVH
`define SMSC_DEFS_SVH
`define SMSC_OFS_CHIP_ID 8'h50
`define SMSC_OFS_ENDIAN 8'h64
`define SMSC_OFS_HW_SETUP 8'h74
`define SMSC_OFS_POWER_MGMT_CONTROL_REGISTER 8'h84
`define SMSC_WORD_MASK 8'hFC
`define SMSC_ENDIAN_PATTERN 32'h8765_4321
`define SMSC_BIT_READY 27
`define SMSC_BIT_XOVR2 26
`define SMSC_BIT_XOVR1 25
`define SMSC_BIT_RSVD_RW 21
`define SMSC_BIT_MBO 20
`define SMSC_BIT_SOFTWARE_RESET_BIT 0
`define SMSC_BIT_PMT_READY 0
`define SMSC_PHY_OVR_EN_BIT 15
`define SMSC_PHY_OVR_VAL_BIT 13
`define SMSC_READY_TIME_NS 1000
`define SMSC_CLK_PERIOD_NS 50
`define SMSC_SOFTWARE_RESET_BIT_PULSE_CYC 4
`endif

// ===== rtl/smsc_pkg.sv
// Types shared by the misc register bank.
package smsc_pkg;
  typedef enum logic [2:0] {
    SMSC_ST_RESET = 3'b001,
    SMSC_ST_WAIT = 3'b010,
    SMSC_ST_READY = 3'b100
  } smsc_state_e;
  typedef logic [31:0] smsc_word_t;
endpackage

// ===== rtl/smsc_ready_seq.sv
// Ready sequencer: holds the ready flag low for a settling time after any reset.
`timescale 1ns/1ps
`include "smsc_defs.svh"
module smsc_ready_seq
  import smsc_pkg::*;
#(
  parameter int SETTLE_CYC = 20
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Restart request from soft or digital reset.
  input wire logic restart,
  // Ready flag.
  output logic ready
);
  smsc_state_e state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;

  // Next-state logic for the settling sequence.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    case (state_reg)
      SMSC_ST_RESET: begin
        cnt_next = 16'h0000;
        ready_next = 1'b0;
        state_next = SMSC_ST_WAIT;
      end
      SMSC_ST_WAIT: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg >= 16'(SETTLE_CYC - 1)) begin
          ready_next = 1'b1;
          state_next = SMSC_ST_READY;
        end
      end
      SMSC_ST_READY: begin
        ready_next = 1'b1;
      end
      default: begin
        state_next = SMSC_ST_RESET;
      end
    endcase
    if (restart) begin
      ready_next = 1'b0;
      state_next = SMSC_ST_RESET;
    end
  end

  // State registers.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= SMSC_ST_RESET;
      cnt_reg <= 16'h0000;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  assign ready = ready_reg;
endmodule

// ===== sim/smsc_misc_regs_props.sv
// Checker for the misc register bank ports.
`timescale 1ns/1ps
module smsc_misc_regs_props #(
  parameter logic [15:0] CHIP_CODE = 16'hA5C3
) (
  // Watched ports.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_rdata,
  input wire logic [15:0] phy1_special_ctrl,
  input wire logic ready_irq_en,
  input wire logic ready_irq,
  input wire logic pmt_ready,
  input wire logic soft_reset_out,
  input wire logic phy1_xovr_en,
  input wire logic cfg_mbo
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_id_hi; host_rd && host_addr == 8'h52 |=> host_rdata == CHIP_CODE; endproperty
  a_id_hi: assert property (p_id_hi) else $error("identity code wrong");
  property p_pb_hi; host_rd && host_addr == 8'h66 |=> host_rdata == 16'h8765; endproperty
  a_pb_hi: assert property (p_pb_hi) else $error("probe upper half wrong");
  property p_pb_lo; host_rd && host_addr == 8'h64 |=> host_rdata == 16'h4321; endproperty
  a_pb_lo: assert property (p_pb_lo) else $error("probe lower half wrong");
  property p_hold; !host_rd |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_irq; $rose(pmt_ready) && ready_irq_en |-> ##[0:1] ready_irq; endproperty
  a_irq: assert property (p_irq) else $error("ready interrupt missing");
  property p_pulse; ready_irq |-> pmt_ready ##1 !ready_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("ready interrupt not a pulse");
  property p_software_reset_bit; $rose(soft_reset_out) |-> soft_reset_out [*5] ##1 !soft_reset_out; endproperty
  a_software_reset_bit: assert property (p_software_reset_bit) else $error("soft reset length wrong");
  property p_sdrop; $rose(soft_reset_out) |=> !pmt_ready; endproperty
  a_sdrop: assert property (p_sdrop) else $error("ready kept in soft reset");
  property p_nowr; host_wr && !pmt_ready && !soft_reset_out |=> $stable(cfg_mbo); endproperty
  a_nowr: assert property (p_nowr) else $error("write honoured before ready");
  property p_ovr; phy1_special_ctrl[15] && $stable(phy1_special_ctrl)
    |=> phy1_xovr_en == phy1_special_ctrl[13]; endproperty
  a_ovr: assert property (p_ovr) else $error("crossover override ignored");
  c_irq: cover property (ready_irq);
  c_software_reset_bit: cover property ($rose(soft_reset_out));
  c_ovr: cover property (phy1_special_ctrl[15] && phy1_xovr_en);
endmodule
bind smsc_misc_regs smsc_misc_regs_props #(.CHIP_CODE(CHIP_CODE)) props (
  .core_clk(core_clk), .reset(reset), .host_rd(host_rd), .host_wr(host_wr),
  .host_addr(host_addr), .host_rdata(host_rdata), .phy1_special_ctrl(phy1_special_ctrl),
  .ready_irq_en(ready_irq_en), .ready_irq(ready_irq), .pmt_ready(pmt_ready),
  .soft_reset_out(soft_reset_out), .phy1_xovr_en(phy1_xovr_en), .cfg_mbo(cfg_mbo));

// ===== sim/smsc_host_model.sv
// Host processor model issuing single-cycle register strobes.
`timescale 1ns/1ps
module smsc_host_model (
  // Bus signals.
  input wire logic core_clk,
  output logic host_rd = 1'b0,
  output logic host_wr = 1'b0,
  output logic [7:0] host_addr = 8'h00,
  output logic [15:0] host_wdata = 16'h0000,
  input wire logic [15:0] host_rdata
);
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1 d = host_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= v;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_wdata <= ~v;
    #1;
  endtask
endmodule

// ===== sim/smsc_misc_regs_bench.sv
// Self-checking bench for the misc register bank.
`timescale 1ns/1ps
module smsc_misc_regs_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic digital_reset = 1'b0;
  logic strap_xovr1 = 1'b1;
  logic strap_xovr2 = 1'b0;
  logic loader_wr = 1'b0;
  logic loader_xovr1 = 1'b0;
  logic loader_xovr2 = 1'b1;
  logic ready_irq_en = 1'b1;
  logic [15:0] phy1_special_ctrl = 16'h0000;
  logic [15:0] phy2_special_ctrl = 16'h0000;
  logic host_rd, host_wr, ready_irq, pmt_ready, soft_reset_out;
  logic phy1_xovr_en, phy2_xovr_en, cfg_mbo, cfg_rsvd;
  logic [7:0] host_addr;
  logic [15:0] host_wdata, host_rdata, d;
  int fails = 0;
  int tests_run = 0;
  int irqs = 0;
  smsc_misc_regs dut (.core_clk(core_clk), .reset(reset), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .digital_reset(digital_reset), .strap_xovr1(strap_xovr1),
    .strap_xovr2(strap_xovr2), .loader_wr(loader_wr), .loader_xovr1(loader_xovr1),
    .loader_xovr2(loader_xovr2), .phy1_special_ctrl(phy1_special_ctrl),
    .phy2_special_ctrl(phy2_special_ctrl), .ready_irq_en(ready_irq_en),
    .ready_irq(ready_irq), .pmt_ready(pmt_ready), .soft_reset_out(soft_reset_out),
    .phy1_xovr_en(phy1_xovr_en), .phy2_xovr_en(phy2_xovr_en), .cfg_mbo(cfg_mbo),
    .cfg_rsvd(cfg_rsvd));
  smsc_host_model host (.core_clk(core_clk), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
  // Clock of 50 ns period.
  always #25 core_clk = ~core_clk;
  // Count ready interrupt pulses.
  always @(posedge core_clk) if (ready_irq === 1'b1) irqs <= irqs + 1;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 60 && pmt_ready !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("ready", 16'h0001, 16'(pmt_ready));
  endtask
  task automatic rd_setup(input string n, input logic [15:0] e);
    host.rd(8'h76, d);
    chk(n, e, d & 16'h0E30);
  endtask
  task automatic t_before_ready;
    host.rd(8'h66, d);
    chk("probe_hi", 16'h8765, d);
    host.rd(8'h64, d);
    chk("probe_lo", 16'h4321, d);
    rd_setup("setup_early", 16'h0200);
    host.wr(8'h76, 16'h0010);
    chk("mbo_early", 16'h0000, 16'(cfg_mbo));
    wait_ready();
    repeat (2) @(posedge core_clk);
    #1 chk("irq", 16'h0001, 16'(irqs));
    host.rd(8'h52, d);
    chk("id_hi", 16'hA5C3, d);
    host.rd(8'h50, d);
    chk("id_lo", 16'h0001, d);
    rd_setup("setup_ready", 16'h0A00);
  endtask
  task automatic t_straps;
    chk("phy1_strap", 16'h0001, 16'(phy1_xovr_en));
    @(posedge core_clk);
    loader_wr <= 1'b1;
    @(posedge core_clk);
    loader_wr <= 1'b0;
    rd_setup("setup_loaded", 16'h0C00);
    chk("phy2_loaded", 16'h0001, 16'(phy2_xovr_en));
    @(posedge core_clk);
    phy1_special_ctrl <= 16'hA000;
    phy2_special_ctrl <= 16'h8000;
    repeat (2) @(posedge core_clk);
    #1 chk("phy1_ovr", 16'h0001, 16'(phy1_xovr_en));
    chk("phy2_ovr", 16'h0000, 16'(phy2_xovr_en));
  endtask
  task automatic t_writes;
    host.wr(8'h76, 16'h0010);
    rd_setup("mbo_set", 16'h0C10);
    chk("mbo_out", 16'h0001, 16'(cfg_mbo));
    host.wr(8'h76, 16'h0010);
    rd_setup("rsvd_zero", 16'h0C10);
    chk("rsvd_out", 16'h0000, 16'(cfg_rsvd));
    host.wr(8'h64, 16'h0000);
    host.rd(8'h64, d);
    chk("probe_ro", 16'h4321, d);
    host.wr(8'h74, 16'h0001);
    chk("software_reset_bit_out", 16'h0001, 16'(soft_reset_out));
    repeat (2) @(posedge core_clk);
    #1 chk("software_reset_bit_mbo", 16'h0000, 16'(cfg_mbo));
    chk("software_reset_bit_ready", 16'h0000, 16'(pmt_ready));
    wait_ready();
    host.rd(8'h74, d);
    chk("software_reset_bit_clear", 16'h0000, d & 16'h0001);
  endtask
  task automatic t_digital;
    @(posedge core_clk);
    digital_reset <= 1'b1;
    ready_irq_en <= 1'b0;
    host.rd(8'h74, d);
    host.rd(8'h74, d);
    chk("dig_bit0", 16'h0001, d & 16'h0001);
    chk("dig_ready", 16'h0000, 16'(pmt_ready));
    @(posedge core_clk);
    digital_reset <= 1'b0;
    wait_ready();
    repeat (2) @(posedge core_clk);
    #1 chk("irq_off", 16'h0002, 16'(irqs));
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_before_ready();
    t_straps();
    t_writes();
    t_digital();
    finish_test();
  end
  // Watchdog against a hang.
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
